// >>> i2csm_map.vh
// register map and field constants for the two-wire slave status and mask block
`ifndef I2CSM_MAP_VH
`define I2CSM_MAP_VH
`define I2CSM_ADR_STATUS 5'h00
`define I2CSM_ADR_MASK 5'h04
`define I2CSM_ADR_RXDATA 5'h08
`define I2CSM_ADR_TXDATA 5'h0c
`define I2CSM_ADR_OWNADDR 5'h10
`define I2CSM_ADR_IRQST 5'h14
`define I2CSM_ADR_IRQEN 5'h18
`define I2CSM_ADR_CTRL 5'h1c
`define I2CSM_BIT_TBF 0
`define I2CSM_BIT_RBF 1
`define I2CSM_BIT_RW 2
`define I2CSM_BIT_START 3
`define I2CSM_BIT_STOP 4
`define I2CSM_BIT_DATA 5
`define I2CSM_BIT_MATCH 6
`define I2CSM_MASK_RST 10'h000
`define I2CSM_OWNADDR_RST 10'h050
`define I2CSM_IRQ_W 5
`define I2CSM_IRQ_START 0
`define I2CSM_IRQ_STOP 1
`define I2CSM_IRQ_MATCH 2
`define I2CSM_IRQ_RXFULL 3
`define I2CSM_IRQ_TXDONE 4
`endif

// >>> i2csm_top.v
// two-wire slave: bus condition detector, 7/10-bit masked address match, status and mask regs
//
// Functional notes
// - data/address flag clears on address match, sets on each further slave byte
// - status bit 4 is one when the last bus condition seen was a stop
// - status bit 3 is one when the last condition was start or repeated start
// - status bit 2 latches read/write bit after an address byte is received
// - receive-full bit 1 sets when a received byte enters the receive register
// - software read of the receive register clears receive-full
// - software write of the transmit register sets transmit-full bit 0
// - transmit-full clears when the held byte has been shifted out
// - mask bit one: that address position is ignored in matching
// - mask bit zero: that address position must equal own address bit
// - mask register bits 15 to 10 read as zero
`timescale 1ns/1ps
`include "i2csm_map.vh"
module i2csm_top (
  input wire clk_i, // system clock, 250 MHz
  input wire rst_i, // synchronous reset, active high
  input wire cyc_i, // wishbone cycle
  input wire stb_i, // wishbone strobe
  input wire we_i, // wishbone write enable
  input wire [3:0] sel_i, // wishbone byte selects
  input wire [4:0] adr_i, // wishbone byte address
  input wire [31:0] dat_i, // wishbone write data
  output reg [31:0] dat_o, // wishbone read data
  output reg ack_o, // wishbone acknowledge
  input wire scl_i, // serial clock pin level
  input wire sda_i, // serial data pin level
  output reg sda_oe_n_o, // sda drive enable, low pulls line low
  output reg irq_o // level interrupt
);
  // two-flop synchronisers for pins
  // the third flop of each chain is only history for edge detection;
  // nothing decodes the first flop, which may still be metastable
  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always @(posedge clk_i) begin
    scl_m_q <= scl_i;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end
  // edges and bus conditions from the synchronised levels; start is sda
  // falling while scl stays high, stop is sda rising while scl stays high.
  // both need scl high for two samples, so a short scl glitch is no start
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // masked compare, shared by both address bytes
  // a set mask bit removes that position from the compare; used selects
  // which positions the current byte carries, so the ten-bit header only
  // checks bits 9..8 and the second byte only bits 7..0
  // limitation: a mask of all ones matches every address in 7-bit mode and every ten-bit address in ten-bit mode
  function match_bits;
    input [9:0] a;
    input [9:0] own;
    input [9:0] msk;
    input [9:0] used;
    begin
      match_bits = ~|(((a ^ own) & ~msk) & used);
    end
  endfunction

  // byte engine states, one-hot:
  //   idle   - no transfer for us, sda released
  //   shift  - eight data or address bits, msb first
  //   ack    - byte complete, decide ack at the next scl fall
  //   ackchk - ninth clock; watch the master's ack on reads
  //   ignore - not addressed, or master nacked; wait for start or stop
  // one-hot costs a few flops but keeps every state decode to one bit
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SHIFT = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_ACKCHK = 5'h08;
  localparam [4:0] S_IGNORE = 5'h10;

  // nbyte_q walks first address byte, second (ten-bit) byte, then data
  // rw_q, start_q, stop_q, data_q, match_q, rbf_q and tbf_q are the
  // status bits; they are separate flops so each has a single writer
  reg [4:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg [1:0] nbyte_q; // 0 first addr, 1 second addr, 2 data
  reg ten_q; // full ten-bit address matched
  reg [7:0] rx_q, tx_q;
  reg [9:0] mask_q, own_q;
  reg ten_en_q;
  reg rw_q, start_q, stop_q, data_q, match_q, rbf_q, tbf_q;
  reg [`I2CSM_IRQ_W-1:0] ist_q, ien_q;
  // event pulses, high for one cycle, merged into the interrupt status;
  // written only by the byte engine, read only by the register process
  reg [`I2CSM_IRQ_W-1:0] ev_q;

  // bus decode; a request is taken once, then ack blocks a second take
  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire wb_wr = wb_req & we_i & sel_i[0];
  wire wb_rd = wb_req & ~we_i;
  // bytev is the shift register with the bit being sampled now appended
  // used7, usedhi and usedlo pick the compared positions per address form
  wire [7:0] bytev = {sh_q[6:0], sda_s_q};
  wire [9:0] used7 = 10'h07f;
  wire [9:0] usedhi = 10'h300;
  wire [9:0] usedlo = 10'h0ff;

  // serial byte engine
  // runs entirely on the system clock; scl and sda are only seen through
  // the synchronisers, so an scl edge is acted on two to three cycles late.
  // at 250 MHz that is about 12 ns, far inside the low phase of any
  // standard bus speed, which is where sda may legally change.
  // start and stop take priority over the byte state machine: a condition
  // in mid-byte aborts the byte, which is what the bus requires.
  // rx full is cleared by a software read first and set by a load later
  // in the same pass, so a load in the same cycle wins over the read.
  // events are collected in ev_q and last exactly one cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      nbyte_q <= 2'h0;
      ten_q <= 1'b0;
      rx_q <= 8'h00;
      rw_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      data_q <= 1'b0;
      match_q <= 1'b0;
      rbf_q <= 1'b0;
      sda_oe_n_o <= 1'b1;
      ev_q <= {`I2CSM_IRQ_W{1'b0}};
    end else begin
      ev_q <= {`I2CSM_IRQ_W{1'b0}};
      // read clear first; a load later in this pass overrides it
      if (wb_rd && adr_i == `I2CSM_ADR_RXDATA) begin
        rbf_q <= 1'b0;
      end
      if (start_det) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
        ev_q[`I2CSM_IRQ_START] <= 1'b1;
        st_q <= S_SHIFT;
        cnt_q <= 4'h0;
        nbyte_q <= 2'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_det) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
        ev_q[`I2CSM_IRQ_STOP] <= 1'b1;
        st_q <= S_IDLE;
        match_q <= 1'b0;
        ten_q <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (st_q)
          S_IDLE: begin
            sda_oe_n_o <= 1'b1;
          end
          S_SHIFT: begin
            // transmit path drives bit on falling edge
            // sda_oe_n low pulls the line, so a data one simply releases it
            if (scl_fall && match_q && rw_q && nbyte_q == 2'h2) begin
              sda_oe_n_o <= tx_q[3'h7 - cnt_q[2:0]];
            end else if (scl_fall) begin
              sda_oe_n_o <= 1'b1;
            end
            if (scl_rise) begin
              sh_q <= bytev;
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == 4'h7) begin
                st_q <= S_ACK;
              end
            end
          end
          S_ACK: begin
            // decide on the byte, drive ack from falling edge
            if (scl_fall) begin
              st_q <= S_ACKCHK;
              cnt_q <= 4'h0;
              sda_oe_n_o <= 1'b1;
              if (nbyte_q == 2'h0) begin
                if (ten_en_q && sh_q[7:3] == 5'b11110 &&
                    match_bits({sh_q[2:1], 8'h00}, own_q, mask_q, usedhi)) begin
                  if (ten_q && sh_q[0]) begin
                    // repeated start read after ten-bit write
                    match_q <= 1'b1;
                    rw_q <= 1'b1;
                    data_q <= 1'b0;
                    nbyte_q <= 2'h2;
                    ev_q[`I2CSM_IRQ_MATCH] <= 1'b1;
                  end else begin
                    rw_q <= sh_q[0];
                    nbyte_q <= 2'h1;
                  end
                  sda_oe_n_o <= 1'b0;
                end else if (!ten_en_q &&
                             match_bits({3'h0, sh_q[7:1]}, own_q, mask_q, used7)) begin
                  match_q <= 1'b1;
                  ten_q <= 1'b0;
                  rw_q <= sh_q[0];
                  data_q <= 1'b0;
                  nbyte_q <= 2'h2;
                  sda_oe_n_o <= 1'b0;
                  ev_q[`I2CSM_IRQ_MATCH] <= 1'b1;
                end else begin
                  st_q <= S_IGNORE;
                end
              end else if (nbyte_q == 2'h1) begin
                if (match_bits({2'h0, sh_q}, own_q, mask_q, usedlo)) begin
                  match_q <= 1'b1;
                  ten_q <= 1'b1;
                  data_q <= 1'b0;
                  nbyte_q <= 2'h2;
                  sda_oe_n_o <= 1'b0;
                  ev_q[`I2CSM_IRQ_MATCH] <= 1'b1;
                end else begin
                  st_q <= S_IGNORE;
                end
              end else if (!rw_q) begin
                // received data byte; nack if previous still unread
                // a nacked byte is lost; software must empty the buffer in time
                data_q <= 1'b1;
                if (!rbf_q) begin
                  rx_q <= sh_q;
                  rbf_q <= 1'b1;
                  ev_q[`I2CSM_IRQ_RXFULL] <= 1'b1;
                  sda_oe_n_o <= 1'b0;
                end
              end else begin
                data_q <= 1'b1;
                ev_q[`I2CSM_IRQ_TXDONE] <= 1'b1;
              end
            end
          end
          S_ACKCHK: begin
            // release after ninth clock; master nack ends a read
            if (scl_rise && rw_q && nbyte_q == 2'h2 && sda_s_q) begin
              st_q <= S_IGNORE;
            end else if (scl_fall) begin
              st_q <= S_SHIFT;
              sda_oe_n_o <= (match_q && rw_q && nbyte_q == 2'h2) ? tx_q[7] : 1'b1;
            end
          end
          S_IGNORE: begin
            sda_oe_n_o <= 1'b1;
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // software registers and transmit holding
  // writes need byte lane 0; lane 1 carries bits 9..8 of mask and own address
  // a write to the transmit register while a byte is on the wire replaces
  // it; software should wait for tx full to drop first
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= 8'h00;
      tbf_q <= 1'b0;
      mask_q <= `I2CSM_MASK_RST;
      own_q <= `I2CSM_OWNADDR_RST;
      ten_en_q <= 1'b0;
      ien_q <= {`I2CSM_IRQ_W{1'b0}};
      ist_q <= {`I2CSM_IRQ_W{1'b0}};
    end else begin
      if (wb_wr && adr_i == `I2CSM_ADR_TXDATA) begin
        tx_q <= dat_i[7:0];
        tbf_q <= 1'b1;
      end else if (ev_q[`I2CSM_IRQ_TXDONE]) begin
        tbf_q <= 1'b0;
      end
      if (wb_wr && adr_i == `I2CSM_ADR_MASK) begin
        mask_q[7:0] <= dat_i[7:0];
        if (sel_i[1]) begin
          mask_q[9:8] <= dat_i[9:8];
        end
      end
      if (wb_wr && adr_i == `I2CSM_ADR_OWNADDR) begin
        own_q[7:0] <= dat_i[7:0];
        if (sel_i[1]) begin
          own_q[9:8] <= dat_i[9:8];
        end
      end
      if (wb_wr && adr_i == `I2CSM_ADR_CTRL) begin
        ten_en_q <= dat_i[0];
      end
      if (wb_wr && adr_i == `I2CSM_ADR_IRQEN) begin
        ien_q <= dat_i[`I2CSM_IRQ_W-1:0];
      end
      // set wins over write-one-to-clear
      ist_q <= (ist_q & ~((wb_wr && adr_i == `I2CSM_ADR_IRQST) ?
               dat_i[`I2CSM_IRQ_W-1:0] : {`I2CSM_IRQ_W{1'b0}})) | ev_q;
    end
  end

  // wishbone answer, one wait state; unmapped reads zero
  // register map, byte offsets on a 32-bit bus:
  //   00 status: b0 tx full, b1 rx full, b2 read/write, b3 start, b4 stop,
  //      b5 data/address, b6 addressed
  //   04 address mask, bits 9..0, upper bits read zero
  //   08 receive holding, read clears rx full
  //   0c transmit holding, write sets tx full
  //   10 own address, 7-bit mode uses bits 6..0
  //   14 interrupt status, write one to clear
  //   18 interrupt enable, same layout as status
  //   1c control, b0 selects ten-bit addressing
  // ack is a one-cycle pulse; masters must drop stb for a cycle between
  // requests. dat_o is zero outside ack so no stale value leaks out.
  // irq_o lags the status by one cycle because it is registered.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
      irq_o <= |(ist_q & ien_q);
      dat_o <= 32'h00000000;
      if (wb_rd) begin
        case (adr_i)
          `I2CSM_ADR_STATUS: dat_o <= {25'h0000000, match_q, data_q, stop_q,
                                      start_q, rw_q, rbf_q, tbf_q};
          `I2CSM_ADR_MASK: dat_o <= {22'h000000, mask_q};
          `I2CSM_ADR_RXDATA: dat_o <= {24'h000000, rx_q};
          `I2CSM_ADR_TXDATA: dat_o <= {24'h000000, tx_q};
          `I2CSM_ADR_OWNADDR: dat_o <= {22'h000000, own_q};
          `I2CSM_ADR_IRQST: dat_o <= {27'h0000000, ist_q};
          `I2CSM_ADR_IRQEN: dat_o <= {27'h0000000, ien_q};
          `I2CSM_ADR_CTRL: dat_o <= {31'h00000000, ten_en_q};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // i2csm_top

// >>> i2csm_props.sv
// checker: bus handshake and register readback properties
`timescale 1ns/1ps
module i2csm_props (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire cyc_i, // cycle
  input wire stb_i, // strobe
  input wire we_i, // write enable
  input wire [3:0] sel_i, // byte selects
  input wire [4:0] adr_i, // address
  input wire [31:0] dat_i, // write data
  input wire [31:0] dat_o, // read data
  input wire ack_o, // acknowledge
  input wire irq_o // interrupt
);
  reg [9:0] msk_q;
  wire take = cyc_i && stb_i && !ack_o;
  wire rd_msk = !we_i && adr_i == 5'h04;
  wire rd_st = !we_i && adr_i == 5'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the mask; only full-lane writes, as the bench makes them
  always @(posedge clk_i) begin
    if (rst_i) msk_q <= 10'h000;
    else if (take && we_i && adr_i == 5'h04 && sel_i[1:0] == 2'b11) msk_q <= dat_i[9:0];
  end
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_after_take: assert property (take |=> ack_o) else $error("ack late");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  a_mask_upper_zero: assert property (ack_o && $past(rd_msk) |-> dat_o[31:10] == 22'h0)
    else $error("mask upper bits set");
  a_mask_read_back: assert property (ack_o && $past(rd_msk) |-> dat_o[9:0] == msk_q)
    else $error("mask readback wrong");
  a_start_stop_excl: assert property (ack_o && $past(rd_st) |-> !(dat_o[3] && dat_o[4]))
    else $error("start and stop both set");
  a_irq_masked_off: assert property (ack_o && $past(we_i && adr_i == 5'h18 && sel_i[0]
    && dat_i[4:0] == 5'h00) |=> !irq_o) else $error("irq while all masked");
endmodule // i2csm_props
bind i2csm_top i2csm_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .irq_o(irq_o));

// >>> i2csm_master.sv
// partner: behavioural two-wire bus master
`timescale 1ns/1ps
module i2csm_master (
  output reg scl_o, // serial clock, still between frames
  output reg sda_o, // data drive, 0 pulls low
  input wire sda_i // resolved line level
);
  localparam real Q = 31.25; // quarter of the 125 ns bit
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task start;
    begin
      sda_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_o = 1'b0;
      #Q scl_o = 1'b0;
      #Q;
    end
  endtask
  task stop;
    begin
      sda_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_o = 1'b1;
      #Q;
    end
  endtask
  // data only changes while clock is low
  task bitx(input b, output r);
    begin
      sda_o = b;
      #Q scl_o = 1'b1;
      #Q r = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
  endtask
  // eight bits msb first, then the ack slot; drive ff to read
  task xfer(input [7:0] d, input last, output [7:0] q, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], q[i]);
      bitx(last, ack);
    end
  endtask
endmodule // i2csm_master

// >>> test_i2c_slave_status_and_mask.sv
// testbench: registers, masked matching and status over the serial bus
`timescale 1ns/1ps
module test_i2c_slave_status_and_mask;
  reg clk_i, rst_i, req, we;
  reg [4:0] adr;
  reg [31:0] dat;
  reg [15:0] r = 16'h003c;
  reg [7:0] q;
  reg a;
  integer bad_count = 0, cmp_count = 0;
  wire [31:0] dat_o;
  wire ack_o, irq_o, scl, m_sda, sda_oe_n;
  wire sda = m_sda & sda_oe_n; // open drain with pull-up
  logic [31:0] exp_q[$], care_q[$];
  i2csm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
    .sel_i(4'hf), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl),
    .sda_i(sda), .sda_oe_n_o(sda_oe_n), .irq_o(irq_o));
  i2csm_master m (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one classic cycle; wait bounded, release after the ack edge
  task wb(input w, input [4:0] ad, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      req <= 1'b1; we <= w; adr <= ad; dat <= d;
      n = 0;
      do begin @(posedge clk_i); n = n + 1; end while (ack_o !== 1'b1 && n < 64);
      if (n >= 64) bad_count = bad_count + 1;
      req <= 1'b0;
    end
  endtask
  task rd(input [4:0] ad, input [31:0] e, input [31:0] c);
    begin
      exp_q.push_back(e);
      care_q.push_back(c);
      wb(1'b0, ad, 32'h0);
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // read monitor takes the oldest note at each read ack
  always @(posedge clk_i) if (ack_o === 1'b1 && we === 1'b0) begin
    check(dat_o & care_q[0], exp_q[0]);
    void'(exp_q.pop_front());
    void'(care_q.pop_front());
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    rst_i = 1'b1; req = 1'b0; we = 1'b0; adr = 5'h00; dat = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h04, 32'h0, 32'hffffffff);
    rd(5'h02, 32'h0, 32'hffffffff);
    r = lfsr(r);
    wb(1'b1, 5'h04, {r, r});
    rd(5'h04, {22'h0, r[9:0]}, 32'hffffffff);
    $display("test reset_and_mask done");
    // own address 50, low two positions ignored
    wb(1'b1, 5'h18, 32'h4);
    wb(1'b1, 5'h04, 32'h3);
    m.start;
    m.xfer(8'ha6, 1'b1, q, a);
    check(a, 1'b0);
    repeat (3) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd(5'h00, 32'h08, 32'h3c);
    r = lfsr(r);
    m.xfer(r[7:0], 1'b1, q, a);
    check(a, 1'b0);
    rd(5'h00, 32'h2a, 32'h3e);
    rd(5'h08, r[7:0], 32'hff);
    rd(5'h00, 32'h28, 32'h3e);
    m.stop;
    rd(5'h00, 32'h10, 32'h18);
    wb(1'b1, 5'h18, 32'h0);
    wb(1'b1, 5'h14, 32'h1f);
    wb(1'b1, 5'h18, 32'h4);
    repeat (3) @(posedge clk_i);
    check(irq_o, 1'b0);
    m.start;
    m.xfer(8'hae, 1'b1, q, a);
    check(a, 1'b1);
    m.stop;
    $display("test write_and_match done");
    r = lfsr(r);
    wb(1'b1, 5'h0c, {24'h0, r[7:0]});
    rd(5'h00, 32'h1, 32'h1);
    m.start;
    m.xfer(8'ha1, 1'b1, q, a);
    check(a, 1'b0);
    rd(5'h00, 32'h0d, 32'h0d);
    m.xfer(8'hff, 1'b1, q, a);
    check(q, r[7:0]);
    rd(5'h00, 32'h0, 32'h1);
    m.stop;
    $display("test read_transfer done");
    // ten-bit own address 2a5, exact match
    wb(1'b1, 5'h04, 32'h0);
    wb(1'b1, 5'h10, 32'h2a5);
    wb(1'b1, 5'h1c, 32'h1);
    m.start;
    m.xfer(8'hf4, 1'b1, q, a);
    check(a, 1'b0);
    m.xfer(8'ha5, 1'b1, q, a);
    check(a, 1'b0);
    rd(5'h00, 32'h08, 32'h3c);
    m.stop;
    m.start;
    m.xfer(8'hf4, 1'b1, q, a);
    m.xfer(8'ha4, 1'b1, q, a);
    check(a, 1'b1);
    m.stop;
    $display("test ten_bit_match done");
    repeat (2) @(posedge clk_i);
    close_out;
  end
endmodule // test_i2c_slave_status_and_mask
